/* src/adcc_conv_if.sv */
// Purpose: carries control and status between the register block, the clock generator and the SAR engine
// Assumes: single clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface adcc_conv_if;
    import adcc_pkg::*;
    adcc_clk_sel_t clk_sel;
    logic sleep;
    logic half_tick;
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic comp;
    adcc_byte_t trial;

    modport ctrl (output clk_sel, output sleep, output start, output abort, output comp,
                  input half_tick, input busy, input done, input trial);
    modport bitclk (input clk_sel, input sleep, input start, input busy, output half_tick);
    modport sar (input half_tick, input start, input abort, input comp,
                 output busy, output done, output trial);
endinterface
`default_nettype wire

/* src/adcc_pkg.sv */
// Purpose: types shared by the converter control modules
// Assumes: nothing beyond the register header
// Notes: numbers live in adcc_regs.svh
`default_nettype none
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_CLK_DIV_A = 2'b00,
        ADCC_CLK_DIV_B = 2'b01,
        ADCC_CLK_DIV_C = 2'b10,
        ADCC_CLK_RC = 2'b11
    } adcc_clk_sel_t;

    typedef enum logic {
        ADCC_SAR_IDLE = 1'b0,
        ADCC_SAR_CONV = 1'b1
    } adcc_sar_state_t;

    typedef logic [7:0] adcc_byte_t;
endpackage
`default_nettype wire

/* src/adcc_regs.svh */
// Purpose: register indices, field positions, reset values and timing counts of the converter control
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_IDX_PORT 8'h05
`define ADCC_IDX_IRQ 8'h0c
`define ADCC_IDX_RESULT 8'h1e
`define ADCC_IDX_CTRL 8'h1f
`define ADCC_IDX_CFG 8'h9f

`define ADCC_CTRL_CLK_HI 7
`define ADCC_CTRL_CLK_LO 6
`define ADCC_CTRL_CHAN_HI 5
`define ADCC_CTRL_CHAN_LO 3
`define ADCC_CTRL_GO 2
`define ADCC_CTRL_ON 0
`define ADCC_CFG_HI 2
`define ADCC_CFG_LO 0
`define ADCC_IRQ_FLAG 0
`define ADCC_IRQ_EN 1
`define ADCC_IRQ_GLOBAL 2

`define ADCC_CTRL_RESET 8'h00
`define ADCC_CFG_RESET 3'h0
`define ADCC_IRQ_RESET 1'b0
`define ADCC_TRIAL_START 8'h80

`define ADCC_CLK_PERIOD_NS 100
`define ADCC_RC_BIT_PERIOD_NS 4000
`define ADCC_DIV_A 2
`define ADCC_DIV_B 8
`define ADCC_DIV_C 32
`define ADCC_HALF_PERIODS_PER_CONV 19
`define ADCC_LAST_DECISION 15

`endif

/* src/adcc_sar.sv */
// Purpose: successive approximation sequencer, one bit decided per bit-conversion period
// Assumes: comp is high when the held input is at or above the trial code
// Notes: a conversion lasts 19 half periods, that is 9.5 bit-conversion periods
`include "adcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module adcc_sar import adcc_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    adcc_conv_if.sar cif
);
    adcc_sar_state_t state;
    logic [4:0] hcnt;
    adcc_byte_t trial;
    logic done;

    function automatic adcc_byte_t decide(input adcc_byte_t cur, input logic [4:0] h, input logic keep);
        logic [2:0] b;
        adcc_byte_t n;
        b = 3'(7 - int'(h[4:1]));
        n = cur;
        if (!keep) begin
            n[b] = 1'b0;
        end
        if (b != 3'd0) begin
            n[b - 3'd1] = 1'b1;
        end
        return n;
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ADCC_SAR_IDLE;
            hcnt <= '0;
            trial <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ADCC_SAR_IDLE: begin
                    if (cif.start) begin
                        state <= ADCC_SAR_CONV;
                        hcnt <= '0;
                        trial <= `ADCC_TRIAL_START;
                    end
                end
                ADCC_SAR_CONV: begin
                    if (cif.abort) begin
                        state <= ADCC_SAR_IDLE;
                    end else if (cif.half_tick) begin
                        hcnt <= hcnt + 5'd1;
                        if (hcnt[0] && hcnt <= 5'(`ADCC_LAST_DECISION)) begin
                            trial <= decide(trial, hcnt, cif.comp);
                        end
                        if (hcnt == 5'(`ADCC_HALF_PERIODS_PER_CONV - 1)) begin
                            done <= 1'b1;
                            state <= ADCC_SAR_IDLE;
                        end
                    end
                end
                default: state <= ADCC_SAR_IDLE;
            endcase
        end
    end

    assign cif.busy = (state == ADCC_SAR_CONV);
    assign cif.done = done;
    assign cif.trial = trial;

    // Helper count of half periods seen in the current conversion
    logic [5:0] seen;
    always_ff @(posedge clk) begin
        if (srst || cif.start) begin
            seen <= '0;
        end else if (cif.busy && cif.half_tick) begin
            seen <= seen + 6'd1;
        end
    end

    chk_conv_length: assert property (@(posedge clk) disable iff (srst)
        cif.done |-> seen == 6'd19)
        else $error("conversion did not last 9.5 bit periods");
    chk_trial_msb_first: assert property (@(posedge clk) disable iff (srst)
        cif.start && !cif.busy |=> cif.busy && cif.trial == 8'h80)
        else $error("conversion did not begin with the top trial bit");
endmodule
`default_nettype wire

/* src/adcc_tad_gen.sv */
// Purpose: half bit-period enable pulses for the selected conversion clock
// Assumes: system clock is the oscillator; the internal RC clock is modelled by a divider
// Notes: pulses only while a conversion is running
`include "adcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module adcc_bitclk_gen import adcc_pkg::*; #(
    parameter int CW = 8,
    parameter int RC_HALF = `ADCC_RC_BIT_PERIOD_NS / (2 * `ADCC_CLK_PERIOD_NS)
) (
    input wire logic clk,
    input wire logic srst,
    adcc_conv_if.bitclk cif
);
    logic [CW-1:0] cnt;
    logic tick;

    function automatic logic [CW-1:0] half_len(input adcc_clk_sel_t sel);
        case (sel)
            ADCC_CLK_DIV_A: half_len = CW'(`ADCC_DIV_A / 2);
            ADCC_CLK_DIV_B: half_len = CW'(`ADCC_DIV_B / 2);
            ADCC_CLK_DIV_C: half_len = CW'(`ADCC_DIV_C / 2);
            default: half_len = (RC_HALF < 1) ? CW'(1) : CW'(RC_HALF);
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (srst || cif.start || !cif.busy) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cif.sleep && cif.clk_sel != ADCC_CLK_RC) begin
            // Oscillator-derived clocks stop in sleep; only the RC clock keeps running
            tick <= 1'b0;
        end else if (cnt == half_len(cif.clk_sel) - CW'(1)) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + CW'(1);
            tick <= 1'b0;
        end
    end

    assign cif.half_tick = tick;

    chk_sleep_halts_clock: assert property (@(posedge clk) disable iff (srst)
        cif.sleep && cif.clk_sel != ADCC_CLK_RC |=> !cif.half_tick)
        else $error("conversion clock ran in sleep without RC source");
endmodule
`default_nettype wire

/* src/adcc_top.sv */
// Purpose: register block and control of an 8-bit successive approximation converter with five inputs
// Assumes: classic Wishbone slave, one registered ack per access, one system clock that is the oscillator
// Notes: result register is never reset; pins and comparator pass a three-stage synchroniser
// Overview of operation
// - Five selectable inputs, successive approximation conversion.
// - Each conversion yields an 8-bit value.
// - Converts in sleep only with RC clock.
// - Reset clears registers except result, converter off, aborts.
// - Clock select bits 7-6 pick divider or RC.
// - Channel bits 5-3 select channels 0-4.
// - Writing go while on starts; reads busy.
// - Completion loads result, clears go, sets flag.
// - Control bit 1 always reads zero.
// - Bit 0 enables; off means shut down.
// - Configuration bits 7-3 read zero.
// - Configuration code maps pins analog or digital.
// - Odd codes below six use external reference.
// - Power-on reset leaves result unmodified.
// - Conversion takes 9.5 bit-conversion periods.
// - Special trigger starts only while converter on.
// - Port reads return zero on analog pins.
//
// Design decision made here: the Wishbone interface to the registers.
`include "adcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module adcc_top import adcc_pkg::*; #(
    parameter int AW = 10,
    parameter int RC_HALF = `ADCC_RC_BIT_PERIOD_NS / (2 * `ADCC_CLK_PERIOD_NS)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep,
    input wire logic special_trigger,
    input wire logic [5:0] port_pins,
    input wire logic comparator_in,
    output logic [2:0] channel_select_o,
    output logic [5:0] analog_enable,
    output logic vref_external,
    output logic sample_hold,
    output logic [7:0] dac_trial,
    output logic converter_powered,
    output logic irq
);
    adcc_conv_if cif ();

    adcc_bitclk_gen #(
        .CW(8),
        .RC_HALF(RC_HALF)
    ) u_bitclk (
        .clk(clk),
        .srst(srst),
        .cif(cif)
    );

    adcc_sar u_sar (
        .clk(clk),
        .srst(srst),
        .cif(cif)
    );

    adcc_clk_sel_t conv_clock_select;
    logic [2:0] channel_select;
    logic go_flag;
    logic converter_on;
    logic [2:0] port_config_select;
    adcc_byte_t conversion_result;
    logic conversion_done_flag;
    logic conversion_irq_enable;
    logic global_irq_enable;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // Bit n is port pin n; pin 4 is never analog, pin 5 carries channel four
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        if (cfg[2:1] == 2'b11) begin
            analog_mask = 6'h00;
        end else if (cfg[2]) begin
            analog_mask = 6'h0b;
        end else begin
            analog_mask = 6'h2f;
        end
    endfunction

    function automatic logic ext_ref(input logic [2:0] cfg);
        ext_ref = cfg[0] && (cfg[2:1] != 2'b11);
    endfunction

    // Bus decode
    logic access;
    logic [7:0] idx;
    logic wr;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_irq;
    assign access = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[9:2];
    // Writes take effect on the edge where the master sees ack
    assign wr = access && wb_we_i && ack && wb_sel_i[0];
    assign wr_ctrl = wr && (idx == `ADCC_IDX_CTRL);
    assign wr_cfg = wr && (idx == `ADCC_IDX_CFG);
    assign wr_irq = wr && (idx == `ADCC_IDX_IRQ);

    always_ff @(posedge clk) begin
        if (srst) begin
            ack <= 1'b0;
        end else begin
            ack <= access && !ack;
        end
    end
    assign wb_ack_o = ack;

    // Pin and comparator synchronisers; a bit changes once stages two and three agree
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_s3;
    logic [5:0] pin_stable;
    logic comp_s1;
    logic comp_s2;
    logic comp_s3;
    logic comp_stable;
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_stable <= '0;
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            comp_s3 <= 1'b0;
            comp_stable <= 1'b0;
        end else begin
            pin_s1 <= port_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 ^ pin_s3));
            comp_s1 <= comparator_in;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            if (comp_s2 == comp_s3) begin
                comp_stable <= comp_s2;
            end
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (srst) begin
            conv_clock_select <= adcc_clk_sel_t'(`ADCC_CTRL_RESET >> `ADCC_CTRL_CLK_LO);
            channel_select <= 3'h0;
            converter_on <= 1'b0;
        end else if (wr_ctrl) begin
            conv_clock_select <= adcc_clk_sel_t'(wb_dat_i[`ADCC_CTRL_CLK_HI:`ADCC_CTRL_CLK_LO]);
            channel_select <= wb_dat_i[`ADCC_CTRL_CHAN_HI:`ADCC_CTRL_CHAN_LO];
            converter_on <= wb_dat_i[`ADCC_CTRL_ON];
        end
    end

    // Go flag: the enable must already be on, so turning on and starting in one write does nothing.
    // Software writing zero is ignored; only completion or switching off clears it.
    logic start_req;
    assign start_req = converter_on && ((wr_ctrl && wb_dat_i[`ADCC_CTRL_GO] && wb_dat_i[`ADCC_CTRL_ON])
                       || special_trigger);
    always_ff @(posedge clk) begin
        if (srst) begin
            go_flag <= 1'b0;
        end else if (!converter_on) begin
            go_flag <= 1'b0;
        end else if (start_req && !go_flag) begin
            go_flag <= 1'b1;
        end else if (cif.done) begin
            go_flag <= 1'b0;
        end
    end

    assign cif.start = start_req && !go_flag;
    assign cif.abort = !converter_on;
    assign cif.clk_sel = conv_clock_select;
    assign cif.sleep = sleep;
    assign cif.comp = comp_stable;

    // Result keeps its content across reset
    always_ff @(posedge clk) begin
        if (cif.done) begin
            conversion_result <= cif.trial;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port_config_select <= `ADCC_CFG_RESET;
        end else if (wr_cfg) begin
            port_config_select <= wb_dat_i[`ADCC_CFG_HI:`ADCC_CFG_LO];
        end
    end

    // Done flag: write one to clear; a completion in the same cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            conversion_done_flag <= `ADCC_IRQ_RESET;
            conversion_irq_enable <= `ADCC_IRQ_RESET;
            global_irq_enable <= `ADCC_IRQ_RESET;
        end else begin
            if (cif.done) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_irq && wb_dat_i[`ADCC_IRQ_FLAG]) begin
                conversion_done_flag <= 1'b0;
            end
            if (wr_irq) begin
                conversion_irq_enable <= wb_dat_i[`ADCC_IRQ_EN];
                global_irq_enable <= wb_dat_i[`ADCC_IRQ_GLOBAL];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
            analog_enable <= 6'h00;
            vref_external <= 1'b0;
            channel_select_o <= 3'h0;
        end else begin
            irq <= conversion_done_flag && conversion_irq_enable && global_irq_enable;
            analog_enable <= analog_mask(port_config_select);
            vref_external <= ext_ref(port_config_select);
            channel_select_o <= channel_select;
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (idx == `ADCC_IDX_CTRL) begin
            next_rdata[7:0] = {conv_clock_select, channel_select, go_flag, 1'b0, converter_on};
        end else if (idx == `ADCC_IDX_CFG) begin
            next_rdata[7:0] = {5'h00, port_config_select};
        end else if (idx == `ADCC_IDX_RESULT) begin
            next_rdata[7:0] = conversion_result;
        end else if (idx == `ADCC_IDX_IRQ) begin
            next_rdata[7:0] = {5'h00, global_irq_enable, conversion_irq_enable, conversion_done_flag};
        end else if (idx == `ADCC_IDX_PORT) begin
            next_rdata[5:0] = pin_stable & ~analog_mask(port_config_select);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (access && !ack) begin
            rdata <= next_rdata;
        end
    end
    assign wb_dat_o = rdata;

    assign sample_hold = cif.busy;
    assign dac_trial = cif.trial;
    assign converter_powered = converter_on;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_sw_start;
        wr_ctrl && wb_dat_i[`ADCC_CTRL_GO] && wb_dat_i[`ADCC_CTRL_ON] && converter_on && !go_flag;
    endsequence
    sequence s_running;
        go_flag && cif.busy;
    endsequence

    chk_reset_state: assert property (disable iff (1'b0) srst |=> !converter_on && !go_flag
        && port_config_select == 3'h0 && !cif.busy)
        else $error("reset did not clear converter state");
    chk_go_starts: assert property (s_sw_start |=> s_running)
        else $error("go write did not start a conversion");
    chk_done_effects: assert property (cif.done && converter_on && !start_req
        |=> !go_flag && conversion_done_flag && conversion_result == $past(cif.trial))
        else $error("completion did not load result and update flags");
    chk_bit1_zero: assert property (ack && !wb_we_i && idx == `ADCC_IDX_CTRL |-> wb_dat_o[1] == 1'b0)
        else $error("control bit 1 read nonzero");
    chk_off_aborts: assert property (!converter_on |=> !go_flag && !cif.busy)
        else $error("converter off but conversion kept running");
    chk_cfg_upper_zero: assert property (ack && !wb_we_i && idx == `ADCC_IDX_CFG |-> wb_dat_o[7:3] == 5'h00)
        else $error("configuration upper bits read nonzero");
    // Map and reference are registered, so they follow the configuration of the cycle before
    chk_pin_mapping: assert property ($stable(port_config_select) |=> analog_enable ==
        ($past(port_config_select[2:1]) == 2'b11 ? 6'h00 : ($past(port_config_select[2]) ? 6'h0b : 6'h2f)))
        else $error("analog pin map does not match configuration");
    chk_vref_select: assert property ($stable(port_config_select) |=>
        vref_external == ($past(port_config_select) inside {3'b001, 3'b011, 3'b101}))
        else $error("reference select does not match configuration");
    chk_trigger_ignored: assert property (special_trigger && !converter_on |=> !go_flag)
        else $error("trigger started a conversion while off");
    chk_trigger_starts: assert property (special_trigger && converter_on && !go_flag |=> go_flag ##1 cif.busy)
        else $error("trigger did not start a conversion");
    chk_analog_reads_zero: assert property (ack && !wb_we_i && idx == `ADCC_IDX_PORT
        |-> (wb_dat_o[5:0] & $past(analog_mask(port_config_select))) == 6'h00)
        else $error("analog pin read as nonzero");
    chk_irq_gating: assert property (irq |-> $past(conversion_done_flag && conversion_irq_enable
        && global_irq_enable))
        else $error("interrupt raised without flag and both enables");
    chk_flag_sticky: assert property (conversion_done_flag && !(wr_irq && wb_dat_i[0]) |=> conversion_done_flag)
        else $error("done flag cleared without software");
endmodule
`default_nettype wire

/* test/adcc_analog_model.sv */
// Purpose: analog side of the converter: five held input levels and an ideal comparator
// Assumes: levels are codes on the selected reference scale
// Notes: outside a conversion the comparator output toggles, since it carries nothing valid then
`timescale 1ns/100ps
`default_nettype none
module adcc_analog_model (
    input wire logic clk,
    input wire logic [39:0] levels,
    input wire logic [2:0] channel_select,
    input wire logic [7:0] dac_trial,
    input wire logic sample_hold,
    output logic comparator
);
    logic [7:0] held;
    logic junk;
    initial begin
        held = 8'h00;
        junk = 1'b0;
    end
    // Track the input until the hold switch opens
    always @(posedge clk) begin
        if (!sample_hold) begin
            held <= (channel_select < 3'h5) ? levels[channel_select*8 +: 8] : 8'h00;
        end
        junk <= ~junk;
    end
    assign comparator = sample_hold ? (held >= dac_trial) : junk;
endmodule
`default_nettype wire

/* test/testbench.sv */
// Purpose: self-checking bench for the converter control
// Assumes: ideal comparator; internal RC half period shortened to 2 cycles
// Notes: durations allow a few cycles of pipeline slack
`include "adcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench import adcc_pkg::*;;
    localparam int RCH = 2;
    typedef struct {logic [7:0] idx; logic [7:0] wd; logic [31:0] rexp;} adcc_row_t;
    adcc_row_t rows[6] = '{'{8'h1f, 8'hfa, 32'hf8}, '{8'h9f, 8'hff, 32'h07}, '{8'h9f, 8'h05, 32'h05},
        '{8'h0c, 8'h06, 32'h06}, '{8'h40, 8'hff, 32'h00}, '{8'h1f, 8'h00, 32'h00}};
    int half[4] = '{1, 4, 16, RCH};
    logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat, wb_dat;
    logic sleep = 1'b0, trig = 1'b0, comp, wb_ack, sh, powered, vref, irq;
    logic [5:0] pins = 6'h3f, aen;
    logic [2:0] chan;
    logic [7:0] trial;
    logic [39:0] levels = {8'h3c, 8'h81, 8'h5a, 8'hff, 8'h00};
    int err_count = 0, total_checks = 0, dur;
    always #50 clk = ~clk;
    adcc_top #(.RC_HALF(RCH)) DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
        .sleep(sleep), .special_trigger(trig), .port_pins(pins), .comparator_in(comp),
        .channel_select_o(chan), .analog_enable(aen), .vref_external(vref), .sample_hold(sh),
        .dac_trial(trial), .converter_powered(powered), .irq(irq));
    adcc_analog_model PART (.clk(clk), .levels(levels), .channel_select(chan), .dac_trial(trial),
        .sample_hold(sh), .comparator(comp));
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_rng(input string nm, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // Ack is sampled at the edge itself, before that edge's updates land
    task wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rdat = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            err_count++;
            conclude();
        end
    endtask
    task rd_chk(input string nm, input logic [7:0] i, input logic [31:0] e);
        wb(1'b0, i, 8'h00);
        chk(nm, e, rdat);
    endtask
    task wait_sh(input logic lvl, input int lim, output int n);
        n = 0;
        while (sh !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            err_count++;
            conclude();
        end
    endtask
    task start(input logic [1:0] cs, input logic [2:0] ch);
        wb(1'b1, 8'h1f, {cs, ch, 3'b001});
        repeat (130) @(posedge clk);
        wb(1'b1, 8'h1f, {cs, ch, 3'b101});
        wait_sh(1'b1, 10, dur);
    endtask
    task conv(input logic [1:0] cs, input logic [2:0] ch);
        start(cs, ch);
        wait_sh(1'b0, 2000, dur);
        repeat (70) @(posedge clk);
    endtask
    task pulse_trig;
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd_chk("ctrl reset", 8'h1f, 32'h0);
        rd_chk("cfg reset", 8'h9f, 32'h0);
        chk("powered reset", 32'h0, powered);
        for (int r = 0; r < 6; r++) begin
            wb(1'b1, rows[r].idx, rows[r].wd);
            rd_chk("reg readback", rows[r].idx, rows[r].rexp);
        end
        wb(1'b1, 8'h0c, 8'h01);
        for (int s = 0; s < 4; s++) begin
            conv(s[1:0], 3'h0);
            chk_rng("conv length", 19 * half[s], 19 * half[s] + 4, dur);
        end
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, 8'h0c, 8'h01);
            conv(2'b10, c[2:0]);
            rd_chk("result", 8'h1e, {24'h0, levels[c*8 +: 8]});
            rd_chk("go cleared", 8'h1f, {24'h0, 2'b10, c[2:0], 3'b001});
            rd_chk("done flag", 8'h0c, 32'h1);
            chk("irq masked", 32'h0, irq);
        end
        wb(1'b1, 8'h0c, 8'h07);
        conv(2'b10, 3'h1);
        chk("irq raised", 32'h1, irq);
        wb(1'b1, 8'h0c, 8'h07);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, irq);
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 8'h9f, k[7:0]);
            repeat (5) @(posedge clk);
            chk("analog map", (k < 4) ? 32'h2f : (k < 6) ? 32'h0b : 32'h0, aen);
            chk("ext ref", {31'h0, k[0] && k < 6}, vref);
            rd_chk("port read", 8'h05, (k < 4) ? 32'h10 : (k < 6) ? 32'h34 : 32'h3f);
        end
        pins <= 6'h15;
        repeat (6) @(posedge clk);
        rd_chk("port pins", 8'h05, 32'h15);
        wb(1'b1, 8'h9f, 8'h00);
        wb(1'b1, 8'h1f, 8'h84);
        rd_chk("go while off", 8'h1f, 32'h80);
        pulse_trig();
        repeat (5) @(posedge clk);
        chk("trigger off", 32'h0, sh);
        wb(1'b1, 8'h1f, 8'h81);
        repeat (130) @(posedge clk);
        pulse_trig();
        wait_sh(1'b1, 10, dur);
        wait_sh(1'b0, 2000, dur);
        repeat (70) @(posedge clk);
        sleep <= 1'b1;
        conv(2'b11, 3'h2);
        chk_rng("sleep rc conv", 19 * RCH, 19 * RCH + 4, dur);
        start(2'b10, 3'h2);
        repeat (400) @(posedge clk);
        chk("sleep freeze", 32'h1, sh);
        sleep <= 1'b0;
        wait_sh(1'b0, 2000, dur);
        repeat (70) @(posedge clk);
        start(2'b10, 3'h3);
        repeat (20) @(posedge clk);
        wb(1'b1, 8'h1f, 8'h98);
        repeat (2) @(posedge clk);
        chk("abort hold", 32'h0, sh);
        chk("powered off", 32'h0, powered);
        rd_chk("abort go", 8'h1f, 32'h98);
        start(2'b10, 3'h3);
        repeat (20) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("reset hold", 32'h0, sh);
        rd_chk("reset ctrl", 8'h1f, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
